// >>> core/cfdfp_pkg.sv
// Package for the CAN FD FIFO status and slot address block
package cfdfp_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFDFP_OFS_EVT_STATUS  = 8'h00;
  localparam logic [7:0] CFDFP_OFS_EVT_CTRL    = 8'h04;
  localparam logic [7:0] CFDFP_OFS_EVT_ADDR    = 8'h08;
  localparam logic [7:0] CFDFP_OFS_TXQ_CTRL    = 8'h0C;
  localparam logic [7:0] CFDFP_OFS_TXQ_ADDR    = 8'h10;
  localparam logic [7:0] CFDFP_OFS_MODE        = 8'h14;
  localparam logic [7:0] CFDFP_OFS_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] CFDFP_OFS_IRQ_MASK    = 8'h1C;
  localparam logic [7:0] CFDFP_OFS_FIFO_CTRL   = 8'h40; // + 4*m, m = 1..15
  localparam logic [7:0] CFDFP_OFS_FIFO_ADDR   = 8'h80; // + 4*m, m = 1..15

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFDFP_BIT_NONEMPTY = 0;
  localparam int CFDFP_BIT_HALF     = 1;
  localparam int CFDFP_BIT_FULL     = 2;
  localparam int CFDFP_BIT_OVERFLOW = 3;
  localparam int CFDFP_BIT_TAIL_ADV = 8;   // control: tail advance request
  localparam int CFDFP_BIT_RESET    = 10;  // control: queue reset request
  localparam int CFDFP_BIT_HEAD_ADV = 9;   // control: head advance (tx queue only; fifos use bit 8)
  localparam int CFDFP_BIT_TXDIR    = 7;   // fifo control: transmit direction select
  localparam int CFDFP_SIZE_LSB     = 24;  // control: size field [28:24]
  localparam int CFDFP_MODE_W       = 3;

  localparam logic [2:0]  CFDFP_MODE_CONFIG = 3'h4;  // binary 100
  localparam logic [2:0]  CFDFP_MODE_RESET  = 3'h4;  // mode after module reset
  localparam logic [4:0]  CFDFP_SIZE_RESET  = 5'h00;
  localparam logic [31:0] CFDFP_READ_ZERO   = 32'h0000_0000;

  // Irq status bits: nonempty, half, full, overflow of the event fifo
  localparam int CFDFP_IRQ_W = 4;

  // ----------------------------------------------------------------------
  // Bus carrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } cfdfp_bus_t;

  // One-fifo pointer pair and fill count
  typedef struct packed {
    logic [4:0] head;
    logic [4:0] tail;
    logic [5:0] count;
  } cfdfp_ptr_t;

endpackage

// >>> core/cfdfp_core.sv
// CAN FD FIFO status flags and slot address registers
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ns
module cfdfp_core
  import cfdfp_pkg::*;
#(
  parameter int NFIFO     = 15,
  parameter int SLOT_W    = 12,                  // not used; the slot index step is MSG_BYTES
  parameter logic [31:0] MSG_BYTES = 32'h0000_0048 // bytes per message slot
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        event_push,          // protocol engine stores one event
  input  wire logic        txq_pop,             // engine sent the queue tail message
  input  wire logic [NFIFO:1] fifo_push,        // engine fills a receive fifo
  input  wire logic [NFIFO:1] fifo_pop,         // engine drains a transmit fifo
  input  wire logic [31:0] event_base,          // message memory base of the event fifo
  input  wire logic [31:0] txq_base,
  input  wire logic [NFIFO:0][31:0] fifo_base,  // entry 0 unused
  output logic             config_mode,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  cfdfp_bus_t bus;
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [2:0] mode_q;
  assign config_mode = (mode_q == CFDFP_MODE_CONFIG);

  // Mode register; no other transition logic lives here
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_q <= CFDFP_MODE_RESET;
    end else if (bus.wr && bus.addr == CFDFP_OFS_MODE) begin
      mode_q <= bus.wdata[CFDFP_MODE_W-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Event fifo
  // ----------------------------------------------------------------------
  cfdfp_ptr_t evt_q;
  logic [4:0] evt_size_q;
  logic       evt_rst_q;      // self-clearing reset request
  logic       evt_ovf_q;
  logic [5:0] evt_depth;
  logic       evt_full, evt_half, evt_nonempty, evt_adv;
  logic       evt_ctrl_wr;

  assign evt_ctrl_wr  = bus.wr && bus.addr == CFDFP_OFS_EVT_CTRL;
  assign evt_depth    = {1'b0, evt_size_q} + 6'd1;
  // Flags are pure decodes of the count and depth, so they track every change
  assign evt_full     = (evt_q.count == evt_depth);
  assign evt_half     = ({evt_q.count, 1'b0} >= {1'b0, evt_depth});
  assign evt_nonempty = (evt_q.count != 6'd0);
  assign evt_adv      = evt_ctrl_wr && bus.wdata[CFDFP_BIT_TAIL_ADV] && evt_nonempty;

  // Size only changes in configuration mode, as the depth steers wrap
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evt_size_q <= CFDFP_SIZE_RESET;
    end else if (evt_ctrl_wr && config_mode) begin
      evt_size_q <= bus.wdata[CFDFP_SIZE_LSB +: 5];
    end
  end

  // Reset request is held one cycle, performed, then dropped
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      evt_rst_q <= 1'b0;
    end else if (evt_rst_q) begin
      evt_rst_q <= 1'b0;
    end else if (evt_ctrl_wr && bus.wdata[CFDFP_BIT_RESET]) begin
      evt_rst_q <= 1'b1;
    end
  end

  // Head, tail and count; a push into a full fifo is dropped
  always_ff @(posedge mclk) begin
    if (!rst_n || evt_rst_q) begin
      evt_q <= '0;
    end else begin
      if (event_push && !evt_full) begin
        evt_q.head <= (evt_q.head == evt_size_q) ? 5'd0 : evt_q.head + 5'd1;
      end
      if (evt_adv) begin
        evt_q.tail <= (evt_q.tail == evt_size_q) ? 5'd0 : evt_q.tail + 5'd1;
      end
      evt_q.count <= evt_q.count + {5'd0, event_push && !evt_full} - {5'd0, evt_adv};
    end
  end

  // Overflow: hardware set beats a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n || evt_rst_q) begin
      evt_ovf_q <= 1'b0;
    end else if (event_push && evt_full) begin
      evt_ovf_q <= 1'b1;
    end else if (bus.wr && bus.addr == CFDFP_OFS_EVT_STATUS
                 && !bus.wdata[CFDFP_BIT_OVERFLOW]) begin
      evt_ovf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit queue: software fills head, engine drains tail
  // ----------------------------------------------------------------------
  cfdfp_ptr_t txq_q;
  logic [4:0] txq_size_q;
  logic       txq_rst_q, txq_ctrl_wr, txq_full, txq_in, txq_out;

  assign txq_ctrl_wr = bus.wr && bus.addr == CFDFP_OFS_TXQ_CTRL;
  assign txq_full    = (txq_q.count == {1'b0, txq_size_q} + 6'd1);
  assign txq_in      = txq_ctrl_wr && bus.wdata[CFDFP_BIT_HEAD_ADV] && !txq_full;
  assign txq_out     = txq_pop && (txq_q.count != 6'd0);

  // Queue size register and self-clearing reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txq_size_q <= CFDFP_SIZE_RESET;
      txq_rst_q  <= 1'b0;
    end else begin
      if (txq_ctrl_wr && config_mode) begin
        txq_size_q <= bus.wdata[CFDFP_SIZE_LSB +: 5];
      end
      txq_rst_q <= !txq_rst_q && txq_ctrl_wr && bus.wdata[CFDFP_BIT_RESET];
    end
  end

  // Queue pointers
  always_ff @(posedge mclk) begin
    if (!rst_n || txq_rst_q) begin
      txq_q <= '0;
    end else begin
      if (txq_in) begin
        txq_q.head <= (txq_q.head == txq_size_q) ? 5'd0 : txq_q.head + 5'd1;
      end
      if (txq_out) begin
        txq_q.tail <= (txq_q.tail == txq_size_q) ? 5'd0 : txq_q.tail + 5'd1;
      end
      txq_q.count <= txq_q.count + {5'd0, txq_in} - {5'd0, txq_out};
    end
  end

  // ----------------------------------------------------------------------
  // General fifos 1..NFIFO, one generate loop
  // ----------------------------------------------------------------------
  logic [NFIFO:0][31:0] fifo_addr;
  logic [NFIFO:0]       fifo_txdir;

  assign fifo_addr[0]  = CFDFP_READ_ZERO;
  assign fifo_txdir[0] = 1'b0;

  for (genvar m = 1; m <= NFIFO; m++) begin : g_fifo
    cfdfp_ptr_t p_q;
    logic [4:0] size_q;
    logic       dir_q, rst_q, cwr, full, push, pop, sw;
    logic [4:0] slot;

    assign cwr  = bus.wr && bus.addr == CFDFP_OFS_FIFO_CTRL + 8'(4 * m);
    assign full = (p_q.count == {1'b0, size_q} + 6'd1);
    // Software advances the head of a tx fifo, the tail of an rx fifo
    assign sw   = cwr && bus.wdata[CFDFP_BIT_TAIL_ADV];
    assign push = dir_q ? (sw && !full) : (fifo_push[m] && !full);
    assign pop  = (dir_q ? fifo_pop[m] : sw) && (p_q.count != 6'd0);

    // Direction and size are configuration-only fields
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        size_q <= CFDFP_SIZE_RESET;
        dir_q  <= 1'b0;
        rst_q  <= 1'b0;
      end else begin
        if (cwr && config_mode) begin
          size_q <= bus.wdata[CFDFP_SIZE_LSB +: 5];
          dir_q  <= bus.wdata[CFDFP_BIT_TXDIR];
        end
        rst_q <= !rst_q && cwr && bus.wdata[CFDFP_BIT_RESET];
      end
    end

    // Pointers
    always_ff @(posedge mclk) begin
      if (!rst_n || rst_q) begin
        p_q <= '0;
      end else begin
        if (push) begin
          p_q.head <= (p_q.head == size_q) ? 5'd0 : p_q.head + 5'd1;
        end
        if (pop) begin
          p_q.tail <= (p_q.tail == size_q) ? 5'd0 : p_q.tail + 5'd1;
        end
        p_q.count <= p_q.count + {5'd0, push} - {5'd0, pop};
      end
    end

    assign slot          = dir_q ? p_q.head : p_q.tail;
    assign fifo_addr[m]  = fifo_base[m] + MSG_BYTES * {27'd0, slot};
    assign fifo_txdir[m] = dir_q;
  end

  // ----------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------
  logic [CFDFP_IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
  logic                   stat_rd;

  assign irq_ev  = {event_push && evt_full, evt_full, evt_half, evt_nonempty};
  assign stat_rd = bus.rd && bus.addr == CFDFP_OFS_IRQ_STATUS;

  // Sticky bits clear on read, but a new event in that cycle stays set
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
    end else begin
      irq_stat_q <= (stat_rd ? '0 : irq_stat_q) | irq_ev;
      if (bus.wr && bus.addr == CFDFP_OFS_IRQ_MASK) begin
        irq_mask_q <= bus.wdata[CFDFP_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------------
  // Read mux, data one cycle after the strobe
  // ----------------------------------------------------------------------
  logic [31:0] rdata_d, evt_addr, txq_addr;
  logic [3:0]  fidx;

  assign evt_addr = event_base + MSG_BYTES * {27'd0, evt_q.tail};
  assign txq_addr = txq_base + MSG_BYTES * {27'd0, txq_q.head};
  assign fidx     = bus.addr[5:2];

  // Unmapped addresses read zero; address registers have no write path
  always_comb begin
    rdata_d = CFDFP_READ_ZERO;
    if (bus.addr == CFDFP_OFS_EVT_STATUS) begin
      rdata_d[CFDFP_BIT_OVERFLOW:0] = {evt_ovf_q, evt_full, evt_half, evt_nonempty};
    end else if (bus.addr == CFDFP_OFS_EVT_CTRL) begin
      rdata_d[CFDFP_SIZE_LSB +: 5]  = evt_size_q;
      rdata_d[CFDFP_BIT_RESET]      = evt_rst_q;
    end else if (bus.addr == CFDFP_OFS_EVT_ADDR) begin
      rdata_d = evt_addr;
    end else if (bus.addr == CFDFP_OFS_TXQ_CTRL) begin
      rdata_d[CFDFP_SIZE_LSB +: 5]  = txq_size_q;
      rdata_d[CFDFP_BIT_RESET]      = txq_rst_q;
    end else if (bus.addr == CFDFP_OFS_TXQ_ADDR) begin
      rdata_d = txq_addr;
    end else if (bus.addr == CFDFP_OFS_MODE) begin
      rdata_d[CFDFP_MODE_W-1:0]     = mode_q;
    end else if (bus.addr == CFDFP_OFS_IRQ_STATUS) begin
      rdata_d[CFDFP_IRQ_W-1:0]      = irq_stat_q;
    end else if (bus.addr == CFDFP_OFS_IRQ_MASK) begin
      rdata_d[CFDFP_IRQ_W-1:0]      = irq_mask_q;
    end else if (bus.addr[7:6] == CFDFP_OFS_FIFO_ADDR[7:6] && fidx != 4'd0) begin
      rdata_d = fifo_addr[fidx];
    end else if (bus.addr[7:6] == CFDFP_OFS_FIFO_CTRL[7:6] && fidx != 4'd0) begin
      rdata_d[CFDFP_BIT_TXDIR]      = fifo_txdir[fidx];
    end
  end

  logic [31:0] rdata_q;

  // Read data register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_q <= CFDFP_READ_ZERO;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= CFDFP_READ_ZERO;
    end
  end

  assign rdata = rdata_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_ovf_on_full: assert property (@(posedge mclk) disable iff (!rst_n)
    event_push && evt_full && !evt_rst_q |=> evt_ovf_q)
    else $error("overflow flag not set on push into full fifo");

  a_ovf_cleared: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_rst_q |=> !evt_ovf_q && evt_q.count == 6'd0)
    else $error("fifo reset left overflow or count");

  // Filling the last free slot must raise full on the next cycle
  a_full_count: assert property (@(posedge mclk) disable iff (!rst_n)
    event_push && !evt_ctrl_wr && !evt_rst_q && evt_q.count + 6'd1 == evt_depth |=> evt_full)
    else $error("full flag not raised on last free slot");

  a_half_level: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_half == (2 * evt_q.count >= evt_depth))
    else $error("half flag disagrees with count");

  a_status_read: assert property (@(posedge mclk) disable iff (!rst_n)
    bus.rd && bus.addr == CFDFP_OFS_EVT_STATUS |=>
      rdata[0] == $past(evt_nonempty) && rdata[31:4] == 28'd0)
    else $error("status read wrong");

  a_tail_step: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_adv && !evt_rst_q |=> evt_q.tail != $past(evt_q.tail) || $past(evt_size_q) == 5'd0)
    else $error("tail did not advance");

  a_rst_clears: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_rst_q |=> !evt_rst_q)
    else $error("reset request did not self clear");

  a_count_bound: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_q.count <= evt_depth)
    else $error("event count above depth");

  // Overflow stays up until software or a fifo reset clears it
  a_ovf_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_ovf_q && !evt_rst_q && !(bus.wr && bus.addr == CFDFP_OFS_EVT_STATUS) |=> evt_ovf_q)
    else $error("overflow flag dropped without a clear");

  // Only a push into a full fifo may raise overflow
  a_ovf_hw_only: assert property (@(posedge mclk) disable iff (!rst_n)
    !evt_ovf_q && !(event_push && evt_full) |=> !evt_ovf_q)
    else $error("overflow flag set without an overflow");

  // Any accepted push, and any dropped push but one at depth 1 with a tail advance, leaves the fifo non-empty
  a_nonempty_push: assert property (@(posedge mclk) disable iff (!rst_n)
    event_push && !evt_rst_q |=> evt_nonempty)
    else $error("not-empty flag low after a push");

  // A tail advance with no push in the same cycle frees one slot
  a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_adv && !event_push && !evt_rst_q |=> evt_q.count == $past(evt_q.count) - 6'd1)
    else $error("tail advance did not free one slot");

  // Read data stand only in the cycle after a read strobe
  a_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    !bus.rd |=> rdata == CFDFP_READ_ZERO)
    else $error("read data not zero outside a read");

  // Depth is frozen outside configuration mode
  a_size_locked: assert property (@(posedge mclk) disable iff (!rst_n)
    evt_ctrl_wr && !config_mode |=> evt_size_q == $past(evt_size_q))
    else $error("event fifo size changed outside configuration");

  // A queue reset restarts the transmit queue empty
  a_txq_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    txq_rst_q |=> txq_q.head == 5'd0 && txq_q.count == 6'd0)
    else $error("queue reset left head or count");

  // Writes to an address register never move its pointer
  a_addr_ro: assert property (@(posedge mclk) disable iff (!rst_n)
    bus.wr && bus.addr == CFDFP_OFS_EVT_ADDR && !evt_rst_q |=> evt_q.tail == $past(evt_q.tail))
    else $error("address register write moved the tail");

endmodule

// >>> tb/cfdfp_engine_model.sv
// Protocol engine model: strobes that fill and drain the message fifos
`timescale 1ns/1ns
module cfdfp_engine_model (
  input  wire logic         mclk,
  output logic              event_push,
  output logic              txq_pop,
  output logic [15:1]       fifo_push,
  output logic [15:1]       fifo_pop,
  output logic [31:0]       event_base,
  output logic [31:0]       txq_base,
  output logic [15:0][31:0] fifo_base
);
  // ----------------------------------------------------------------------
  // Memory layout
  // ----------------------------------------------------------------------
  // Distinct bases so that a wrong fifo selection shows up in the address
  assign event_base = 32'h0000_1000;
  assign txq_base   = 32'h0000_2000;
  for (genvar m = 0; m < 16; m++) begin : g_base
    assign fifo_base[m] = 32'h0001_0000 + 32'(m) * 32'h0000_0100;
  end

  // ----------------------------------------------------------------------
  // Strobes
  // ----------------------------------------------------------------------
  // Idle at time zero so no stray event is counted during reset
  initial begin
    event_push = 1'b0;
    txq_pop    = 1'b0;
    fifo_push  = '0;
    fifo_pop   = '0;
  end

  // One-cycle pulse: 0 event, 1 queue pop, 2 fifo push, other fifo pop
  task automatic pulse(input int kind, input int m);
    @(posedge mclk);
    case (kind)
      0: event_push <= 1'b1;
      1: txq_pop <= 1'b1;
      2: fifo_push[m] <= 1'b1;
      default: fifo_pop[m] <= 1'b1;
    endcase
    @(posedge mclk);
    event_push <= 1'b0;
    txq_pop    <= 1'b0;
    fifo_push  <= '0;
    fifo_pop   <= '0;
    #1;
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the fifo status flags and slot address registers
`timescale 1ns/1ns
module tb;
  import cfdfp_pkg::*;
  logic              mclk;
  logic              rst_n;
  logic [7:0]        addr;
  logic [31:0]       wdata;
  logic              wr;
  logic              rd;
  logic [31:0]       rdata;
  logic              event_push;
  logic              txq_pop;
  logic [15:1]       fifo_push;
  logic [15:1]       fifo_pop;
  logic [31:0]       event_base;
  logic [31:0]       txq_base;
  logic [15:0][31:0] fifo_base;
  logic              config_mode;
  logic              irq;
  logic [31:0]       d;
  int                err_total;
  int                n_checks;
  int                cyc;
  localparam logic [31:0] SZ  = 32'h0300_0000; // depth 4
  localparam logic [31:0] ADV = 32'h0000_0100;
  localparam logic [31:0] RST = 32'h0000_0400;
  localparam logic [31:0] HD  = 32'h0000_0200;
  localparam logic [31:0] TX  = 32'h0000_0080;
  localparam logic [31:0] STP = 32'h0000_0048;
  // Rows: events pushed, status expected afterwards
  int          pushes [4]  = '{1, 1, 2, 1};
  logic [31:0] exp_sta [4] = '{32'h0000_0001, 32'h0000_0003, 32'h0000_0007, 32'h0000_000F};

  cfdfp_core dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .event_push(event_push), .txq_pop(txq_pop), .fifo_push(fifo_push),
    .fifo_pop(fifo_pop), .event_base(event_base), .txq_base(txq_base),
    .fifo_base(fifo_base), .config_mode(config_mode), .irq(irq));

  cfdfp_engine_model u_eng (.mclk(mclk), .event_push(event_push), .txq_pop(txq_pop),
    .fifo_push(fifo_push), .fifo_pop(fifo_pop), .event_base(event_base),
    .txq_base(txq_base), .fifo_base(fifo_base));

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  // 25 MHz clock
  always #20 mclk = ~mclk;

  // A hang costs a mismatch and still reaches the verdict
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      summarize();
    end
  end

  // ----------------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample right there
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk32(input logic [31:0] e, input logic [31:0] g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic chk1(input logic e, input logic g);
    n_checks = n_checks + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Size and direction only take in configuration mode, so set them first
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    wr = 1'b0;
    rd = 1'b0;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk1(1'b1, config_mode);
    chk1(1'b0, irq);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0000, d);
    rd_reg(8'h3C, d);
    chk32(32'h0000_0000, d);
    done("reset");
    wr_reg(CFDFP_OFS_EVT_CTRL, SZ);
    wr_reg(CFDFP_OFS_TXQ_CTRL, SZ);
    wr_reg(CFDFP_OFS_FIFO_CTRL + 8'h04, SZ | TX);
    wr_reg(CFDFP_OFS_FIFO_CTRL + 8'h08, SZ);
    wr_reg(CFDFP_OFS_MODE, 32'h0000_0000);
    chk1(1'b0, config_mode);
    for (int m = 1; m <= 15; m++) begin
      rd_reg(CFDFP_OFS_FIFO_ADDR + 8'(4 * m), d);
      chk32(32'h0001_0000 + 32'(m) * 32'h0000_0100, d);
    end
    done("config");
    for (int i = 0; i < 4; i++) begin
      repeat (pushes[i]) u_eng.pulse(0, 0);
      rd_reg(CFDFP_OFS_EVT_STATUS, d);
      chk32(exp_sta[i], d);
    end
    done("fill");
    chk1(1'b0, irq);
    wr_reg(CFDFP_OFS_IRQ_MASK, 32'h0000_0008);
    chk1(1'b1, irq);
    rd_reg(CFDFP_OFS_IRQ_STATUS, d);
    chk32(32'h0000_000F, d);
    chk1(1'b0, irq);
    done("interrupt");
    wr_reg(CFDFP_OFS_EVT_STATUS, 32'hFFFF_FFF7);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0007, d);
    rd_reg(CFDFP_OFS_EVT_ADDR, d);
    chk32(32'h0000_1000, d);
    wr_reg(CFDFP_OFS_EVT_ADDR, 32'hFFFF_FFFF);
    wr_reg(CFDFP_OFS_EVT_CTRL, SZ | ADV);
    rd_reg(CFDFP_OFS_EVT_ADDR, d);
    chk32(32'h0000_1000 + STP, d);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0003, d);
    repeat (2) u_eng.pulse(0, 0);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_000F, d);
    done("advance");
    wr_reg(CFDFP_OFS_EVT_CTRL, SZ | RST);
    for (int k = 0; k < 10; k++) begin
      rd_reg(CFDFP_OFS_EVT_CTRL, d);
      if (d[CFDFP_BIT_RESET] === 1'b0) break;
    end
    chk1(1'b0, d[CFDFP_BIT_RESET]);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0000, d);
    rd_reg(CFDFP_OFS_EVT_ADDR, d);
    chk32(32'h0000_1000, d);
    done("fifo reset");
    rd_reg(CFDFP_OFS_TXQ_ADDR, d);
    chk32(32'h0000_2000, d);
    wr_reg(CFDFP_OFS_TXQ_CTRL, SZ | HD);
    u_eng.pulse(1, 0);
    rd_reg(CFDFP_OFS_TXQ_ADDR, d);
    chk32(32'h0000_2000 + STP, d);
    wr_reg(CFDFP_OFS_FIFO_CTRL + 8'h04, SZ | TX | ADV);
    u_eng.pulse(3, 1);
    rd_reg(CFDFP_OFS_FIFO_ADDR + 8'h04, d);
    chk32(32'h0001_0100 + STP, d);
    repeat (2) u_eng.pulse(2, 2);
    rd_reg(CFDFP_OFS_FIFO_ADDR + 8'h08, d);
    chk32(32'h0001_0200, d);
    wr_reg(CFDFP_OFS_FIFO_CTRL + 8'h08, SZ | ADV);
    rd_reg(CFDFP_OFS_FIFO_ADDR + 8'h08, d);
    chk32(32'h0001_0200 + STP, d);
    done("slot address");
    // Per-queue resets, and flag bits that must ignore writes
    wr_reg(CFDFP_OFS_FIFO_CTRL + 8'h04, SZ | TX | RST);
    rd_reg(CFDFP_OFS_FIFO_CTRL + 8'h04, d);
    chk32(TX, d);
    rd_reg(CFDFP_OFS_FIFO_ADDR + 8'h04, d);
    chk32(32'h0001_0100, d);
    wr_reg(CFDFP_OFS_TXQ_CTRL, SZ | RST);
    rd_reg(CFDFP_OFS_TXQ_ADDR, d);
    chk32(32'h0000_2000, d);
    wr_reg(CFDFP_OFS_EVT_STATUS, 32'h0000_0007);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0000, d);
    done("queue reset");
    // Module reset in mid-run must drop overflow and pointers
    repeat (5) u_eng.pulse(0, 0);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_000F, d);
    chk1(1'b1, irq);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk1(1'b1, config_mode);
    chk1(1'b0, irq);
    rd_reg(CFDFP_OFS_EVT_STATUS, d);
    chk32(32'h0000_0000, d);
    done("module reset");
    summarize();
  end
endmodule
